// file: design/sirqs_pkg.sv
// Constants, register map and carrier types for the serial interrupt slave.
// Assumes a 32-bit APB master with byte-addressed, word-aligned accesses.
package sirqs_pkg;

  // Printed register offsets are indices; byte address is four times.
  localparam logic [3:0] IDX_WAKE_GLOBAL_EN = 4'h1;
  localparam logic [3:0] IDX_WAKE_STS_ONE   = 4'h2;
  localparam logic [3:0] IDX_WAKE_STS_TWO   = 4'h3;
  localparam logic [3:0] IDX_WAKE_EN_ONE    = 4'h5;
  localparam logic [3:0] IDX_WAKE_EN_TWO    = 4'h6;
  localparam logic [3:0] IDX_MGMT_STS_ONE   = 4'h8;
  localparam logic [3:0] IDX_MGMT_STS_TWO   = 4'h9;
  localparam logic [3:0] IDX_MGMT_EN_ONE    = 4'ha;
  localparam logic [3:0] IDX_MGMT_EN_TWO    = 4'hb;
  localparam logic [3:0] IDX_ROUTE_A        = 4'hc;
  localparam logic [3:0] IDX_ROUTE_B        = 4'hd;
  localparam logic [3:0] IDX_GPIO_POL       = 4'he;
  localparam logic [3:0] IDX_IRQ_LEVELS     = 4'hf;

  localparam int unsigned ADDR_IDX_LSB = 2;
  localparam int unsigned ADDR_IDX_MSB = 5;

  // Field positions.
  localparam int unsigned BIT_WAKE_GLOBAL = 0;
  localparam int unsigned BIT_IN1_WAKE    = 3;
  localparam int unsigned BIT_IN2_WAKE    = 5;
  localparam int unsigned BIT_IN3_WAKE    = 2;
  localparam int unsigned BIT_IN1_MGMT    = 3;
  localparam int unsigned BIT_IN2_MGMT    = 4;
  localparam int unsigned BIT_MGMT_FRAME  = 6;
  localparam int unsigned BIT_MGMT_PIN    = 7;
  localparam int unsigned BIT_MODE_QUIET  = 16;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [3:0]  ROUTE_OFF   = 4'h0;
  localparam logic [3:0]  SLOT_MGMT   = 4'h2;
  localparam logic [15:0] LEVELS_IDLE = 16'hffff;

  // Frame timing in bus clocks.
  localparam logic [1:0] PHASE_SAMPLE  = 2'd0;
  localparam logic [1:0] PHASE_RECOVER = 2'd1;
  localparam logic [1:0] PHASE_TURN    = 2'd2;
  localparam logic [4:0] FRAME_LAST    = 5'd16;
  localparam logic [4:0] FRAME_FIRST   = 5'd1;
  localparam logic [1:0] SAMPLE_DELAY  = 2'd1;
  localparam logic [2:0] STOP_QUIET    = 3'd2;
  localparam logic [2:0] STOP_CONT     = 3'd3;
  localparam logic [2:0] START_GAP     = 3'd1;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } sirqs_pin_t;

  typedef struct packed {
    logic [3:0] in3;
    logic [3:0] in2;
    logic [3:0] in1;
  } sirqs_route_t;

endpackage : sirqs_pkg

// file: design/sirqs_top.sv
// Serial interrupt slave with three routed inputs, wake and management bits.
// Assumes the bus line is resolved outside, pins synchronous to pclk.
// Operation
// - Count data frames from the rising edge ending any start pulse.
// - Each data frame is three clocks: sample, recovery, turn-around.
// - Drive low in an owned sample phase only when its level is low.
// - Drive high in recovery only after driving low in sample.
// - Release the line during every turn-around phase.
// - Report low levels regardless of which agent started the cycle.
// - Frame n sample falls 3n-1 clocks after the start rising edge.
// - Frame 1 unused, frame 2 is IRQ1, frame 3 IRQ2 or management.
// - Management bit 6 puts it in frame, bit 7 on its pin.
// - Stop pulse of two clocks means quiet, three means continuous.
// - Start may begin two clocks after stop rise; quiet lets anyone.
// - Drive and sample the line on the rising pclk edge.
// - Line released in reset; slaves start in continuous mode.
// - Each routed input has a 4-bit slot field; zero disables.
// - Nonzero field forwards the pin level even in GPIO use.
// - Routed inputs set wake status bits; wake pin needs both enables.
// - Inputs 1 and 2 set management status; input 3 never does.
// - Event edge chosen by the pin's polarity bit.
// - In quiet idle, a level change starts a one-clock low pulse.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sirqs_top
  import sirqs_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               serirq_in,
  output logic                    serirq_out,
  output logic                    serirq_oe,
  input  wire logic [15:0]        internal_irq_levels,
  input  wire logic               mgmt_interrupt_frame,
  input  wire logic               routed_irq_input_1,
  input  wire logic               routed_irq_input_2,
  input  wire logic               routed_irq_input_3,
  output logic                    mgmt_interrupt_pin_n,
  output logic                    wake_event_pin_n
);
  import sirqs_pkg::*;

  typedef enum logic [2:0] {
    SIRQS_IDLE, SIRQS_START, SIRQS_FRAMES, SIRQS_WAIT_STOP, SIRQS_STOP,
    SIRQS_GAP
  } sirqs_state_t;

  sirqs_state_t state_q;
  logic [7:0]   wake_glb_q, wake_sts1_q, wake_sts2_q, wake_en1_q, wake_en2_q;
  logic [7:0]   mgmt_sts1_q, mgmt_sts2_q, mgmt_en1_q, mgmt_en2_q;
  sirqs_route_t route_q;
  logic [2:0]   pol_q;
  logic [2:0]   in_prev_q;
  logic         line_q;
  logic [4:0]   frame_q;
  logic [1:0]   phase_q;
  logic [1:0]   lead_q;
  logic [2:0]   low_cnt_q;
  logic [2:0]   gap_q;
  logic         quiet_q;
  logic         drove_low_q;
  logic [15:0]  sent_q;
  logic [4:0]   slot_idx;
  logic         start_drive_q;
  logic [15:0]  slot_level;
  logic [2:0]   pins;
  logic [2:0]   edge_hit;
  logic         acc_wr, acc_rd;
  logic [3:0]   idx;
  logic         own_low;
  logic         mgmt_event;
  logic         changed;

  assign pins = {routed_irq_input_3, routed_irq_input_2, routed_irq_input_1};
  assign idx  = paddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Slot levels: internal sources ANDed with routed pins and management.
  always_comb begin
    slot_level = internal_irq_levels;
    for (int i = 1; i < 16; i++) begin
      if (route_q.in1 == 4'(i) && !routed_irq_input_1) begin
        slot_level[i] = 1'b0;
      end
      if (route_q.in2 == 4'(i) && !routed_irq_input_2) begin
        slot_level[i] = 1'b0;
      end
      if (route_q.in3 == 4'(i) && !routed_irq_input_3) begin
        slot_level[i] = 1'b0;
      end
    end
    if (mgmt_en2_q[BIT_MGMT_FRAME] && !mgmt_interrupt_frame) begin
      slot_level[SLOT_MGMT] = 1'b0;
    end
    slot_level[0] = 1'b1;
  end

  // Edge events; polarity bit set selects a rising edge, else falling.
  assign edge_hit = (pol_q & pins & ~in_prev_q) |
                    (~pol_q & ~pins & in_prev_q);
  assign mgmt_event = (mgmt_en1_q[BIT_IN1_MGMT] & mgmt_sts1_q[BIT_IN1_MGMT]) |
                      (mgmt_en2_q[BIT_IN2_MGMT] & mgmt_sts2_q[BIT_IN2_MGMT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_q <= 3'b000;
    end else begin
      in_prev_q <= pins;
    end
  end

  // Register writes; status bits clear on writing one, set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_glb_q  <= REG_RESET;
      wake_sts1_q <= REG_RESET;
      wake_sts2_q <= REG_RESET;
      wake_en1_q  <= REG_RESET;
      wake_en2_q  <= REG_RESET;
      mgmt_sts1_q <= REG_RESET;
      mgmt_sts2_q <= REG_RESET;
      mgmt_en1_q  <= REG_RESET;
      mgmt_en2_q  <= REG_RESET;
      route_q     <= '{ROUTE_OFF, ROUTE_OFF, ROUTE_OFF};
      pol_q       <= 3'b000;
    end else begin
      if (acc_wr) begin
        case (idx)
          IDX_WAKE_GLOBAL_EN: wake_glb_q <= pwdata[7:0];
          IDX_WAKE_STS_ONE:   wake_sts1_q <= wake_sts1_q & ~pwdata[7:0];
          IDX_WAKE_STS_TWO:   wake_sts2_q <= wake_sts2_q & ~pwdata[7:0];
          IDX_WAKE_EN_ONE:    wake_en1_q <= pwdata[7:0];
          IDX_WAKE_EN_TWO:    wake_en2_q <= pwdata[7:0];
          IDX_MGMT_STS_ONE:   mgmt_sts1_q <= mgmt_sts1_q & ~pwdata[7:0];
          IDX_MGMT_STS_TWO:   mgmt_sts2_q <= mgmt_sts2_q & ~pwdata[7:0];
          IDX_MGMT_EN_ONE:    mgmt_en1_q <= pwdata[7:0];
          IDX_MGMT_EN_TWO:    mgmt_en2_q <= pwdata[7:0];
          IDX_ROUTE_A:        route_q.in1 <= pwdata[3:0];
          IDX_ROUTE_B: begin
            route_q.in2 <= pwdata[3:0];
            route_q.in3 <= pwdata[7:4];
          end
          IDX_GPIO_POL:       pol_q <= pwdata[2:0];
          default: ;
        endcase
      end
      // Sets are applied after the clear so a simultaneous event survives.
      if (edge_hit[0]) begin
        wake_sts1_q[BIT_IN1_WAKE] <= 1'b1;
        mgmt_sts1_q[BIT_IN1_MGMT] <= 1'b1;
      end
      if (edge_hit[1]) begin
        wake_sts2_q[BIT_IN2_WAKE] <= 1'b1;
        mgmt_sts2_q[BIT_IN2_MGMT] <= 1'b1;
      end
      if (edge_hit[2]) begin
        wake_sts2_q[BIT_IN3_WAKE] <= 1'b1;
      end
    end
  end

  // Read mux; unmapped indices read zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc_rd) begin
      case (idx)
        IDX_WAKE_GLOBAL_EN: prdata[7:0] = wake_glb_q;
        IDX_WAKE_STS_ONE:   prdata[7:0] = wake_sts1_q;
        IDX_WAKE_STS_TWO:   prdata[7:0] = wake_sts2_q;
        IDX_WAKE_EN_ONE:    prdata[7:0] = wake_en1_q;
        IDX_WAKE_EN_TWO:    prdata[7:0] = wake_en2_q;
        IDX_MGMT_STS_ONE:   prdata[7:0] = mgmt_sts1_q;
        IDX_MGMT_STS_TWO:   prdata[7:0] = mgmt_sts2_q;
        IDX_MGMT_EN_ONE:    prdata[7:0] = mgmt_en1_q;
        IDX_MGMT_EN_TWO:    prdata[7:0] = mgmt_en2_q;
        IDX_ROUTE_A:        prdata[3:0] = route_q.in1;
        IDX_ROUTE_B:        prdata[7:0] = {route_q.in3, route_q.in2};
        IDX_GPIO_POL:       prdata[2:0] = pol_q;
        IDX_IRQ_LEVELS: begin
          prdata[15:0] = slot_level;
          prdata[BIT_MODE_QUIET] = quiet_q;
        end
        default: ;
      endcase
    end
  end

  // Wake and management pins, active low, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_pin_n     <= 1'b1;
      mgmt_interrupt_pin_n <= 1'b1;
    end else begin
      wake_event_pin_n <= !(wake_glb_q[BIT_WAKE_GLOBAL] &&
        ((wake_en1_q[BIT_IN1_WAKE] && wake_sts1_q[BIT_IN1_WAKE]) ||
         (wake_en2_q[BIT_IN2_WAKE] && wake_sts2_q[BIT_IN2_WAKE]) ||
         (wake_en2_q[BIT_IN3_WAKE] && wake_sts2_q[BIT_IN3_WAKE])));
      mgmt_interrupt_pin_n <= !(mgmt_en2_q[BIT_MGMT_PIN] &&
        (mgmt_event || !mgmt_interrupt_frame));
    end
  end

  // Frame n carries slot n-1, so frame 16 still reaches the top slot.
  assign slot_idx = frame_q - FRAME_FIRST;
  assign own_low  = !slot_level[slot_idx[3:0]];
  assign changed = (slot_level != sent_q);

  // Serial frame tracker; the line is sampled on each rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= SIRQS_IDLE;
      line_q      <= 1'b1;
      frame_q     <= FRAME_FIRST;
      phase_q     <= PHASE_SAMPLE;
      lead_q      <= 2'd0;
      low_cnt_q   <= 3'd0;
      gap_q       <= 3'd0;
      quiet_q     <= 1'b0;
      drove_low_q <= 1'b0;
      sent_q      <= LEVELS_IDLE;
      start_drive_q <= 1'b0;
    end else begin
      line_q        <= serirq_in;
      start_drive_q <= 1'b0;
      case (state_q)
        SIRQS_IDLE: begin
          if (!serirq_in) begin
            state_q <= SIRQS_START;
          end else if (quiet_q && changed && !start_drive_q) begin
            start_drive_q <= 1'b1;
          end
        end
        SIRQS_START: begin
          if (serirq_in && !line_q) begin
            state_q <= SIRQS_FRAMES;
            frame_q <= FRAME_FIRST;
            lead_q  <= SAMPLE_DELAY;
            phase_q <= PHASE_TURN;
          end
        end
        SIRQS_FRAMES: begin
          if (lead_q != 2'd0) begin
            lead_q <= lead_q - 2'd1;
            phase_q <= PHASE_SAMPLE;
          end else begin
            case (phase_q)
              PHASE_SAMPLE: begin
                phase_q     <= PHASE_RECOVER;
                drove_low_q <= own_low;
                sent_q[slot_idx[3:0]] <= slot_level[slot_idx[3:0]];
              end
              PHASE_RECOVER: phase_q <= PHASE_TURN;
              default: begin
                phase_q     <= PHASE_SAMPLE;
                drove_low_q <= 1'b0;
                if (frame_q == FRAME_LAST) begin
                  state_q <= SIRQS_WAIT_STOP;
                end else begin
                  frame_q <= frame_q + FRAME_FIRST;
                end
              end
            endcase
          end
        end
        SIRQS_WAIT_STOP: begin
          if (!serirq_in) begin
            state_q   <= SIRQS_STOP;
            low_cnt_q <= 3'd1;
          end
        end
        SIRQS_STOP: begin
          if (!serirq_in) begin
            low_cnt_q <= low_cnt_q + 3'd1;
          end else begin
            quiet_q <= (low_cnt_q == STOP_QUIET);
            state_q <= SIRQS_GAP;
            gap_q   <= START_GAP;
          end
        end
        SIRQS_GAP: begin
          if (gap_q != 3'd0) begin
            gap_q <= gap_q - 3'd1;
          end else begin
            state_q <= SIRQS_IDLE;
          end
        end
        default: state_q <= SIRQS_IDLE;
      endcase
    end
  end

  // Line drive: start pulse low, low in owned sample, high in recovery after a low sample, released otherwise.
  always_comb begin
    serirq_out = 1'b1;
    serirq_oe  = 1'b0;
    if (start_drive_q) begin
      serirq_out = 1'b0;
      serirq_oe  = 1'b1;
    end else if (state_q == SIRQS_FRAMES && lead_q == 2'd0) begin
      if (phase_q == PHASE_SAMPLE && own_low) begin
        serirq_out = 1'b0;
        serirq_oe  = 1'b1;
      end else if (phase_q == PHASE_RECOVER && drove_low_q) begin
        serirq_out = 1'b1;
        serirq_oe  = 1'b1;
      end
    end
  end

  property p_recover_after_low;
    @(posedge pclk) disable iff (!presetn)
      (serirq_oe && !serirq_out && state_q == SIRQS_FRAMES) |=>
        (serirq_oe && serirq_out) ##1 !serirq_oe;
  endproperty
  a_recover_after_low: assert property (p_recover_after_low)
    else $error("Recovery drive missing after a low sample.");

  property p_reset_mode;
    @(posedge pclk) $rose(presetn) |-> !quiet_q && !serirq_oe;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("Slave not continuous and released after reset.");

  property p_start_pulse_one;
    @(posedge pclk) disable iff (!presetn)
      start_drive_q |=> !start_drive_q;
  endproperty
  a_start_pulse_one: assert property (p_start_pulse_one)
    else $error("Start drive lasted more than one clock.");

  property p_first_sample;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SIRQS_START && serirq_in && !line_q) |=>
        ##1 (phase_q == PHASE_SAMPLE && lead_q == 2'd0 &&
             frame_q == FRAME_FIRST);
  endproperty
  a_first_sample: assert property (p_first_sample)
    else $error("First sample phase not at clock two.");

  property p_quiet_no_drive;
    @(posedge pclk) disable iff (!presetn)
      (start_drive_q) |-> $past(quiet_q) && $past(state_q == SIRQS_IDLE);
  endproperty
  a_quiet_no_drive: assert property (p_quiet_no_drive)
    else $error("Start frame driven outside quiet idle.");

  property p_frame_three;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SIRQS_FRAMES && lead_q == 2'd0 &&
       phase_q == PHASE_SAMPLE) |=>
        phase_q == PHASE_RECOVER ##1 phase_q == PHASE_TURN;
  endproperty
  a_frame_three: assert property (p_frame_three)
    else $error("Data frame is not three clocks.");

  property p_turn_release;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SIRQS_FRAMES && phase_q == PHASE_TURN) |-> !serirq_oe;
  endproperty
  a_turn_release: assert property (p_turn_release)
    else $error("Line driven in turn-around.");

  property p_slot_zero;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SIRQS_FRAMES && frame_q == FRAME_FIRST &&
       phase_q == PHASE_SAMPLE && lead_q == 2'd0) |-> !serirq_oe;
  endproperty
  a_slot_zero: assert property (p_slot_zero)
    else $error("Unused frame one was driven.");

  property p_stop_width;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SIRQS_STOP && serirq_in && low_cnt_q == STOP_CONT) |=>
        !quiet_q;
  endproperty
  a_stop_width: assert property (p_stop_width)
    else $error("Three-clock stop did not select continuous mode.");

endmodule : sirqs_top
`default_nettype wire

// file: verification/sirqs_host_model.sv
// Host side of the serial interrupt bus: start, sampling and stop frames.
// Assumes the bench resolves a pulled-up line from every driver.
`timescale 1ns/10ps
`default_nettype none
module sirqs_host_model (
  input  wire logic   pclk,
  input  wire logic   line,
  output logic        drv_out,
  output logic        drv_oe,
  output logic [16:0] samp
);
  initial begin
    drv_out = 1'b1;
    drv_oe  = 1'b0;
    samp    = '1;
  end

  // Called just after a rising edge. With ext set, the host takes over a
  // start pulse that another agent began, as a real host has to.
  task automatic run_cycle(input int stop_len, input bit ext);
    int n;
    n = 0;
    while (ext && line !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    drv_oe  <= 1'b1;
    drv_out <= 1'b0;
    repeat (ext ? 3 : 4) @(posedge pclk);
    drv_out <= 1'b1;
    @(posedge pclk);
    drv_oe <= 1'b0;
    for (int f = 1; f <= 17; f++) begin
      repeat (f == 1 ? 2 : 3) @(posedge pclk);
      if (f <= 16) samp[f] = line;
    end
    repeat (2) @(posedge pclk);
    drv_oe  <= 1'b1;
    drv_out <= 1'b0;
    repeat (stop_len) @(posedge pclk);
    drv_out <= 1'b1;
    @(posedge pclk);
    drv_oe <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : run_cycle
endmodule : sirqs_host_model
`default_nettype wire

// file: verification/tb_serial_irq_slave_with_routed_inputs.sv
// Self-checking bench for the serial interrupt slave and routed inputs.
// Assumes the host model on a pulled-up line and a zero-wait APB slave.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_irq_slave_with_routed_inputs;
  import sirqs_pkg::*;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] paddr    = '0;
  logic [31:0] pwdata   = '0;
  logic [15:0] lv       = 16'hffff;
  logic        mgmt_src = 1'b1;
  logic [3:1]  rin      = 3'b111;
  logic [31:0] prdata;
  logic        pready;
  logic        d_out;
  logic        d_oe;
  logic        h_out;
  logic        h_oe;
  logic [16:0] samp;
  logic        mgmt_pin_n;
  logic        wake_pin_n;
  int          n_mismatch = 0;
  int          n_compared = 0;
  wire logic   line = (d_oe ? d_out : 1'b1) & (h_oe ? h_out : 1'b1);
  localparam logic [3:0] RW_IDX [6] = '{IDX_WAKE_GLOBAL_EN,
    IDX_WAKE_EN_ONE, IDX_WAKE_EN_TWO, IDX_MGMT_EN_ONE, IDX_MGMT_EN_TWO,
    IDX_ROUTE_B};

  sirqs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .serirq_in(line),
    .serirq_out(d_out), .serirq_oe(d_oe), .internal_irq_levels(lv),
    .mgmt_interrupt_frame(mgmt_src), .routed_irq_input_1(rin[1]),
    .routed_irq_input_2(rin[2]), .routed_irq_input_3(rin[3]),
    .mgmt_interrupt_pin_n(mgmt_pin_n), .wake_event_pin_n(wake_pin_n));

  sirqs_host_model host (.pclk(pclk), .line(line), .drv_out(h_out),
    .drv_oe(h_oe), .samp(samp));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the caller stands just after a rising edge.
  task automatic apb(input logic [3:0] idx, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {26'h0, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    apb(idx, 1'b1, d, rd);
  endtask : wr

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    apb(idx, 1'b0, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rdc

  function automatic logic [16:0] expv(input logic [16:0] low);
    return {lv[15:1], 2'b11} & ~low;
  endfunction : expv

  task automatic cyc(input int stop_len, input logic [16:0] exp);
    host.run_cycle(stop_len, 1'b0);
    chk({15'h0, samp}, {15'h0, exp});
  endtask : cyc

  task automatic t_regs;
    for (int i = 1; i < 15; i++) begin
      rdc(i[3:0], {24'h0, REG_RESET});
    end
    rdc(IDX_IRQ_LEVELS, 32'h0000_ffff);
    foreach (RW_IDX[i]) begin
      wr(RW_IDX[i], 32'h0000_005a);
      rdc(RW_IDX[i], 32'h0000_005a);
      wr(RW_IDX[i], 32'h0000_0000);
    end
    wr(4'h0, 32'h0000_00ff);
    rdc(4'h0, 32'h0000_0000);
  endtask : t_regs

  task automatic t_frames;
    lv <= 16'h3fdb;
    @(posedge pclk);
    cyc(3, expv(17'h0));
    lv <= 16'hffff;
    @(posedge pclk);
  endtask : t_frames

  task automatic t_route;
    wr(IDX_ROUTE_A, 32'h0000_0005);
    wr(IDX_ROUTE_B, 32'h0000_0097);
    rin <= 3'b000;
    @(posedge pclk);
    cyc(3, expv(17'h0_0540));
    rdc(IDX_WAKE_STS_ONE, 32'h0000_0008);
    rdc(IDX_WAKE_STS_TWO, 32'h0000_0024);
    rdc(IDX_MGMT_STS_ONE, 32'h0000_0008);
    rdc(IDX_MGMT_STS_TWO, 32'h0000_0010);
    wr(IDX_WAKE_GLOBAL_EN, 32'h0000_0001);
    wr(IDX_WAKE_EN_ONE, 32'h0000_0008);
    wr(IDX_MGMT_EN_ONE, 32'h0000_0008);
    wr(IDX_MGMT_EN_TWO, 32'h0000_0080);
    // The pins are registered one clock behind the enable write.
    @(posedge pclk);
    chk({30'h0, wake_pin_n, mgmt_pin_n}, 32'h0);
    wr(IDX_WAKE_STS_ONE, 32'h0000_00ff);
    wr(IDX_MGMT_STS_ONE, 32'h0000_00ff);
    wr(IDX_WAKE_STS_TWO, 32'h0000_00ff);
    chk({30'h0, wake_pin_n, mgmt_pin_n}, 32'h3);
    wr(IDX_GPIO_POL, 32'h0000_0007);
    rin <= 3'b111;
    @(posedge pclk);
    rdc(IDX_WAKE_STS_TWO, 32'h0000_0024);
    wr(IDX_WAKE_STS_TWO, 32'h0000_00ff);
    rin <= 3'b000;
    @(posedge pclk);
    rdc(IDX_WAKE_STS_TWO, 32'h0000_0000);
    wr(IDX_ROUTE_A, 32'h0000_0000);
    cyc(3, expv(17'h0_0500));
    rin <= 3'b111;
    wr(IDX_ROUTE_B, 32'h0000_0000);
    wr(IDX_MGMT_EN_TWO, 32'h0000_0000);
  endtask : t_route

  task automatic t_mgmt;
    mgmt_src <= 1'b0;
    wr(IDX_MGMT_EN_TWO, 32'h0000_00c0);
    cyc(3, expv(17'h0_0008));
    chk({31'h0, mgmt_pin_n}, 32'h0);
    wr(IDX_MGMT_EN_TWO, 32'h0000_0000);
    cyc(3, expv(17'h0));
    chk({31'h0, mgmt_pin_n}, 32'h1);
    mgmt_src <= 1'b1;
    @(posedge pclk);
  endtask : t_mgmt

  // The slave opens the cycle itself; it must pull low for one clock only.
  task automatic watch_start;
    int n;
    n = 0;
    while (!(d_oe === 1'b1 && d_out === 1'b0) && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 100}, 32'h1);
    @(posedge pclk);
    chk({31'h0, d_oe}, 32'h0);
  endtask : watch_start

  task automatic t_quiet;
    cyc(2, expv(17'h0));
    rdc(IDX_IRQ_LEVELS, 32'h0001_ffff);
    lv <= 16'hfdff;
    fork
      host.run_cycle(3, 1'b1);
      watch_start();
    join
    chk({15'h0, samp}, {15'h0, expv(17'h0)});
    rdc(IDX_IRQ_LEVELS, 32'h0000_fdff);
  endtask : t_quiet

  initial begin
    repeat (4) @(posedge pclk);
    chk({31'h0, d_oe}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_frames();
    t_route();
    t_mgmt();
    t_quiet();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end
endmodule : tb_serial_irq_slave_with_routed_inputs
`default_nettype wire
